/* touch_adc_control.sv */
// Behaviour
// - In wait-for-touch mode a stylus press raises the touch interrupt.
// - Halt select bit 2 stops conversion; X and Y results are kept.
// - Control bit 15 is read-only done flag: 0 busy, 1 ended.
// - With start-on-read bit 1 set, a result read while idle starts a conversion, unless halted or in wait-for-touch.
// - Start bit 0 begins a conversion, self-clears; ignored if read-start.
// - Control bit 14 enables the converter clock divider; reset 0.
// - Bits 13:6 hold divider N, clock divided by N+1; reset 0xff.
// - Bits 5:3 pick analog channel 0 to 7; 7 is the X-plus pad.
// - Touch bit 7 drives the Y-minus switch: 1 grounds it; reset 0.
// - Touch bit 6 drives active-low Y-plus switch; reset 1.
// - Touch bit 5 drives the X-minus switch: 1 grounds it; reset 0.
// - Touch bit 4 drives active-low X-plus switch.
// - Touch bit 3 is the inverted X-plus pull-up enable.
// - Touch bit 2 selects normal or automatic X-then-Y measurement.
// - Touch bits 1:0: none, X, Y or wait-for-touch; reset 00.
// - The 16-bit delay field sets the wait before each conversion.
// - After stylus down the delay paces repeated touch interrupts.
// - One conversion takes five converter clock cycles.
// - Automatic mode stores X, then Y, then raises the done interrupt.
// - Result bit 15 shows stylus state: 0 pressed, 1 released.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns
`include "touch_adc_defines.svh"

module touch_adc_control
   import touch_adc_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        stylus_down_n,
   input  wire logic [9:0]  adc_data,
   output logic      [2:0]  adc_channel,
   output logic             adc_start,
   output logic             adc_tick,
   output logic             adc_standby,
   output logic             yminus_drive,
   output logic             yplus_drive_n,
   output logic             xminus_drive,
   output logic             xplus_drive_n,
   output logic             xplus_pullup_n,
   output logic             touch_irq,
   output logic             conv_irq
);

   // ========================================================
   // Registers
   logic        conv_done_flag;
   logic        divider_enable;
   logic [7:0]  divider_value;
   logic [2:0]  channel_select;
   logic        halt_select;
   logic        read_start;
   logic        start_req;
   logic [8:0]  touch_pad_control;
   logic [15:0] conversion_delay;
   logic [9:0]  x_result;
   logic [9:0]  y_result;

   logic        wr_en;
   logic        rd_done;
   logic        launch;
   logic        finish;
   logic        tick;
   logic [7:0]  div_cnt;
   logic [2:0]  tick_cnt;
   logic [15:0] dly_cnt;
   logic [15:0] touch_cnt;
   logic        y_phase;
   logic        stylus_meta;
   logic        stylus_sync;
   logic        stylus_last;
   logic        mapped;
   conv_state_e state;
   measure_e    measure;

   assign measure = measure_e'(touch_pad_control[`TP_MEAS_HI:`TP_MEAS_LO]);

   function automatic logic is_result(input logic [31:0] a);
      is_result = (a == `OFS_FIRST_RESULT) || (a == `OFS_SECOND_RESULT);
   endfunction : is_result

   // ========================================================
   // APB slave: one wait state so read data comes from a flop
   assign wr_en   = psel & penable & pready & pwrite;
   assign rd_done = psel & penable & pready & ~pwrite;
   assign mapped  = (paddr == `OFS_CONVERTER_CONTROL) |
                    (paddr == `OFS_TOUCH_PAD_CONTROL) |
                    (paddr == `OFS_CONVERSION_DELAY) | is_result(paddr);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~mapped;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (psel && penable && !pready) begin
         prdata <= 32'h0;
         case (paddr)
            `OFS_CONVERTER_CONTROL:
               prdata[15:0] <= {conv_done_flag, divider_enable,
                                divider_value, channel_select,
                                halt_select, read_start, start_req};
            `OFS_TOUCH_PAD_CONTROL: prdata[8:0] <= touch_pad_control;
            `OFS_CONVERSION_DELAY:  prdata[15:0] <= conversion_delay;
            `OFS_FIRST_RESULT:
               prdata[15:0] <= {stylus_sync, touch_pad_control[2:0],
                                2'h0, x_result};
            `OFS_SECOND_RESULT:
               prdata[15:0] <= {stylus_sync, touch_pad_control[2:0],
                                2'h0, y_result};
            default: prdata <= 32'h0;
         endcase
      end
   end

   // ========================================================
   // Control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         divider_enable <= 1'b0;
         divider_value  <= `RST_DIV_VAL;
         channel_select <= 3'h0;
         halt_select    <= 1'b0;
         read_start     <= 1'b0;
      end else if (wr_en && paddr == `OFS_CONVERTER_CONTROL) begin
         divider_enable <= pwdata[`CC_DIV_EN];
         divider_value  <= pwdata[`CC_DIV_HI:`CC_DIV_LO];
         channel_select <= pwdata[`CC_CH_HI:`CC_CH_LO];
         halt_select    <= pwdata[`CC_HALT];
         read_start     <= pwdata[`CC_RD_START];
      end
   end

   // Write-1 request; launch clears it, a fresh write wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_req <= 1'b0;
      end else if (wr_en && paddr == `OFS_CONVERTER_CONTROL &&
                   pwdata[`CC_START] && !pwdata[`CC_RD_START]) begin
         start_req <= 1'b1;
      end else if (launch || read_start) begin
         start_req <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         touch_pad_control <= `RST_TOUCH;
         conversion_delay  <= `RST_DELAY;
      end else if (wr_en) begin
         if (paddr == `OFS_TOUCH_PAD_CONTROL)
            touch_pad_control <= pwdata[8:0];
         if (paddr == `OFS_CONVERSION_DELAY)
            conversion_delay <= pwdata[15:0];
      end
   end

   // ========================================================
   // Converter clock divider
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt <= 8'h0;
         tick    <= 1'b0;
      end else if (!divider_enable || halt_select) begin
         div_cnt <= 8'h0;
         tick    <= 1'b0;
      end else if (div_cnt >= divider_value) begin
         div_cnt <= 8'h0;
         tick    <= 1'b1;
      end else begin
         div_cnt <= div_cnt + 8'h1;
         tick    <= 1'b0;
      end
   end

   // ========================================================
   // Conversion sequencer
   assign launch = (state == st_idle) && !halt_select &&
                   measure != meas_touch &&
                   (start_req || (read_start && rd_done &&
                                  is_result(paddr)));
   assign finish = (state == st_conv) && tick &&
                   tick_cnt == `CONV_TICKS - 3'h1;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state    <= st_idle;
         dly_cnt  <= 16'h0;
         tick_cnt <= 3'h0;
         y_phase  <= 1'b0;
      end else if (halt_select) begin
         state <= st_idle;
      end else begin
         case (state)
            st_idle: begin
               if (launch) begin
                  state   <= st_delay;
                  dly_cnt <= 16'h0;
                  y_phase <= 1'b0;
               end
            end
            st_delay: begin
               if (dly_cnt >= conversion_delay) begin
                  state    <= st_conv;
                  tick_cnt <= 3'h0;
               end else begin
                  dly_cnt <= dly_cnt + 16'h1;
               end
            end
            st_conv: begin
               if (tick)
                  tick_cnt <= tick_cnt + 3'h1;
               if (finish) begin
                  if (touch_pad_control[`TP_AUTO] && !y_phase) begin
                     state   <= st_delay;
                     dly_cnt <= 16'h0;
                     y_phase <= 1'b1;
                  end else begin
                     state <= st_idle;
                  end
               end
            end
            default: state <= st_idle;
         endcase
      end
   end

   // Results hold their value while halted
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         x_result <= 10'h0;
         y_result <= 10'h0;
      end else if (finish && !halt_select) begin
         if (touch_pad_control[`TP_AUTO] && y_phase)
            y_result <= adc_data;
         else
            x_result <= adc_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_done_flag <= 1'b0;
         conv_irq       <= 1'b0;
      end else begin
         conv_irq <= 1'b0;
         if (launch) begin
            conv_done_flag <= 1'b0;
         end else if (finish && !halt_select &&
                      (!touch_pad_control[`TP_AUTO] || y_phase)) begin
            conv_done_flag <= 1'b1;
            conv_irq       <= 1'b1;
         end
      end
   end

   // ========================================================
   // Stylus detect and touch interrupt pacing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stylus_meta <= 1'b1;
         stylus_sync <= 1'b1;
         stylus_last <= 1'b1;
      end else begin
         stylus_meta <= stylus_down_n;
         stylus_sync <= stylus_meta;
         stylus_last <= stylus_sync;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         touch_irq <= 1'b0;
         touch_cnt <= 16'h0;
      end else begin
         touch_irq <= 1'b0;
         if (measure != meas_touch || stylus_sync) begin
            touch_cnt <= 16'h0;
         end else if (stylus_last) begin
            touch_irq <= 1'b1;
            touch_cnt <= 16'h0;
         end else if (touch_cnt >= conversion_delay) begin
            touch_irq <= 1'b1;
            touch_cnt <= 16'h0;
         end else begin
            touch_cnt <= touch_cnt + 16'h1;
         end
      end
   end

   // ========================================================
   // Pad switches and converter controls; automatic mode
   // overrides the pad bits per phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         yminus_drive   <= 1'b0;
         yplus_drive_n  <= 1'b1;
         xminus_drive   <= 1'b0;
         xplus_drive_n  <= 1'b1;
         xplus_pullup_n <= 1'b1;
         adc_channel    <= 3'h0;
      end else if (touch_pad_control[`TP_AUTO] && state != st_idle) begin
         yminus_drive   <= y_phase;
         yplus_drive_n  <= ~y_phase;
         xminus_drive   <= ~y_phase;
         xplus_drive_n  <= y_phase;
         xplus_pullup_n <= 1'b1;
         adc_channel    <= y_phase ? `CH_XPLUS : `CH_YPLUS;
      end else begin
         yminus_drive   <= touch_pad_control[`TP_YMINUS];
         yplus_drive_n  <= touch_pad_control[`TP_YPLUS];
         xminus_drive   <= touch_pad_control[`TP_XMINUS];
         xplus_drive_n  <= touch_pad_control[`TP_XPLUS];
         xplus_pullup_n <= touch_pad_control[`TP_PULLUP];
         adc_channel    <= channel_select;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adc_start   <= 1'b0;
         adc_tick    <= 1'b0;
         adc_standby <= 1'b0;
      end else begin
         adc_start   <= (state == st_delay) &&
                        dly_cnt >= conversion_delay;
         adc_tick    <= tick && state == st_conv;
         adc_standby <= halt_select;
      end
   end

   // ========================================================
   // Checks
   sequence s_launch;
      launch;
   endsequence
   sequence s_done_low;
      !conv_done_flag [*2];
   endsequence

   property p_done_drop;
      @(posedge pclk) disable iff (!presetn)
      s_launch |=> s_done_low;
   endproperty
   a_done_drop: assert property (p_done_drop)
      else $error("done flag not cleared on launch");

   property p_halt_hold;
      @(posedge pclk) disable iff (!presetn)
      halt_select |=> $stable(x_result) && $stable(y_result);
   endproperty
   a_halt_hold: assert property (p_halt_hold)
      else $error("result changed while halted");

   property p_start_clear;
      @(posedge pclk) disable iff (!presetn)
      launch |=> !start_req || $past(wr_en);
   endproperty
   a_start_clear: assert property (p_start_clear)
      else $error("start bit not cleared");

   property p_touch_first;
      @(posedge pclk) disable iff (!presetn)
      measure == meas_touch && !stylus_sync && stylus_last
         |=> touch_irq;
   endproperty
   a_touch_first: assert property (p_touch_first)
      else $error("no touch interrupt on press");

   property p_no_touch_up;
      @(posedge pclk) disable iff (!presetn)
      $past(stylus_sync) |-> !touch_irq;
   endproperty
   a_no_touch_up: assert property (p_no_touch_up)
      else $error("touch interrupt while released");

   property p_div_off;
      @(posedge pclk) disable iff (!presetn)
      !divider_enable |=> !tick;
   endproperty
   a_div_off: assert property (p_div_off)
      else $error("converter tick with divider off");

   property p_yminus;
      @(posedge pclk) disable iff (!presetn)
      state == st_idle |=> yminus_drive == $past(touch_pad_control[7]);
   endproperty
   a_yminus: assert property (p_yminus)
      else $error("Y-minus switch mismatch");

   property p_read_start;
      @(posedge pclk) disable iff (!presetn)
      rd_done && is_result(paddr) && read_start && state == st_idle &&
      !halt_select && measure != meas_touch |=> state == st_delay;
   endproperty
   a_read_start: assert property (p_read_start)
      else $error("read did not start conversion");

   property p_five_ticks;
      @(posedge pclk) disable iff (!presetn)
      finish |-> tick_cnt == 3'h4;
   endproperty
   a_five_ticks: assert property (p_five_ticks)
      else $error("conversion length wrong");

endmodule : touch_adc_control

/* touch_adc_defines.svh */
`ifndef TOUCH_ADC_DEFINES_SVH
`define TOUCH_ADC_DEFINES_SVH
// ==========================================================
// Register map
`define OFS_CONVERTER_CONTROL 32'h5800_0000
`define OFS_TOUCH_PAD_CONTROL 32'h5800_0004
`define OFS_CONVERSION_DELAY  32'h5800_0008
`define OFS_FIRST_RESULT      32'h5800_000c
`define OFS_SECOND_RESULT     32'h5800_0010
// ==========================================================
// Converter control fields
`define CC_DONE      15
`define CC_DIV_EN    14
`define CC_DIV_HI    13
`define CC_DIV_LO    6
`define CC_CH_HI     5
`define CC_CH_LO     3
`define CC_HALT      2
`define CC_RD_START  1
`define CC_START     0
`define RST_DIV_VAL  8'hff
// ==========================================================
// Touch pad control fields
`define TP_YMINUS    7
`define TP_YPLUS     6
`define TP_XMINUS    5
`define TP_XPLUS     4
`define TP_PULLUP    3
`define TP_AUTO      2
`define TP_MEAS_HI   1
`define TP_MEAS_LO   0
`define RST_TOUCH    9'h058
`define RST_DELAY    16'h00ff
// ==========================================================
// Result fields and timing
`define RES_STYLUS   15
`define RES_AUTO     14
`define RES_MEAS_HI  13
`define RES_MEAS_LO  12
`define CONV_TICKS   3'h5
`define CH_XPLUS     3'h7
`define CH_YPLUS     3'h5
`endif

/* touch_adc_pkg.sv */
package touch_adc_pkg;
   typedef enum logic [1:0] {
      meas_none  = 2'h0,
      meas_x     = 2'h1,
      meas_y     = 2'h2,
      meas_touch = 2'h3
   } measure_e;
   typedef enum logic [2:0] {
      st_idle  = 3'h1,
      st_delay = 3'h2,
      st_conv  = 3'h4
   } conv_state_e;
endpackage : touch_adc_pkg

/* touch_panel_model.sv */
`timescale 1ns/1ns

// ==========================================================
// Panel and converter front end seen from the control block
module touch_panel_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       pressed,
   input  wire logic [2:0] adc_channel,
   input  wire logic       adc_start,
   input  wire logic       adc_tick,
   output logic            stylus_down_n,
   output logic      [9:0] adc_data
);
   logic [9:0] held;
   logic [3:0] ticks;
   logic       valid;

   // Pressed stylus pulls the sense line low
   assign stylus_down_n = ~pressed;
   // Stale sample is inverted so a late capture cannot match by luck
   assign adc_data = valid ? held : ~held;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         held  <= 10'h000;
         ticks <= 4'h0;
         valid <= 1'b0;
      end else if (adc_start) begin
         held  <= {adc_channel, 7'h35};
         ticks <= 4'h0;
         valid <= 1'b1;
      end else if (ticks == 4'h7) begin
         valid <= 1'b0;
      end else if (adc_tick || ticks >= 4'h5) begin
         ticks <= ticks + 4'h1;
      end
   end
endmodule : touch_panel_model

/* tb_touch_adc_control.sv */
`timescale 1ns/1ns
`include "touch_adc_defines.svh"

module tb_touch_adc_control;
   import touch_adc_pkg::*;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, err, stylus_down_n, pressed = 0;
   logic [9:0]  adc_data;
   logic [2:0]  adc_channel;
   logic        adc_start, adc_tick, adc_standby, touch_irq, conv_irq;
   logic        yminus_drive, yplus_drive_n, xminus_drive, xplus_drive_n;
   logic        xplus_pullup_n;
   int          error_cnt = 0, tests_run = 0;
   int          starts = 0, irqs = 0, touches = 0, ticks = 0;
   int          cyc = 0, last_touch = 0, gap = 0;
   logic [2:0]  ch_at_start;

   always #20 pclk = ~pclk;

   touch_adc_control touch_adc_control_i (.*);
   touch_panel_model touch_panel_model_i (.*);

   // ==========================================================
   // Event monitor, sampled on the design's own clock
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (adc_start) begin
         starts      <= starts + 1;
         ticks       <= 0;
         ch_at_start <= adc_channel;
      end else if (adc_tick) ticks <= ticks + 1;
      if (conv_irq) irqs <= irqs + 1;
      if (touch_irq) begin
         touches    <= touches + 1;
         gap        <= cyc - last_touch;
         last_touch <= cyc;
      end
   end

   // ==========================================================
   // Checking and bus tasks
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check

   task automatic stop_test;
      $display("checks %0d, errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : stop_test

   // Request held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [31:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (n == 50) begin
         error_cnt++;
         stop_test();
      end
      // Values seen at the edge where pready is sampled high
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic settle;
      repeat (2) @(posedge pclk);
      @(negedge pclk);
   endtask : settle

   // Bounded wait for a count to reach a target
   task automatic wait_for(ref int cnt, input int target);
      int n;
      for (n = 0; n < 2000 && cnt < target; n++) @(negedge pclk);
      if (cnt < target) begin
         error_cnt++;
         stop_test();
      end
   endtask : wait_for

   // ==========================================================
   // Main sequence
   initial begin
      int i, s0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      settle();
      check("pads", {yminus_drive, yplus_drive_n, xminus_drive,
             xplus_drive_n, xplus_pullup_n}, 5'b01011);
      apb(0, `OFS_CONVERTER_CONTROL, 0);
      check("ctrl reset", rd, 32'h0000_3fc0);
      apb(0, `OFS_TOUCH_PAD_CONTROL, 0);
      check("touch reset", rd, 32'h0000_0058);
      apb(0, `OFS_CONVERSION_DELAY, 0);
      check("delay reset", rd, 32'h0000_00ff);
      apb(0, 32'h5800_0020, 0);
      check("unmapped err", {31'h0, err}, 32'h1);
      check("unmapped data", rd, 32'h0);

      // Pad switches follow the register directly
      apb(1, `OFS_TOUCH_PAD_CONTROL, 32'h0a0);
      settle();
      check("pads", {yminus_drive, yplus_drive_n, xminus_drive,
             xplus_drive_n, xplus_pullup_n}, 5'b10100);
      apb(1, `OFS_TOUCH_PAD_CONTROL, 32'h058);
      apb(1, `OFS_CONVERSION_DELAY, 32'h2);

      // Start-bit conversion on every channel
      for (i = 0; i < 8; i++) begin
         s0 = irqs;
         apb(1, `OFS_CONVERTER_CONTROL, 32'h40c1 | (i << 3));
         apb(0, `OFS_CONVERTER_CONTROL, 0);
         check("done busy", rd[15], 1'b0);
         wait_for(irqs, s0 + 1);
         check("channel", ch_at_start, i[2:0]);
         check("ticks", ticks, 5);
         apb(0, `OFS_CONVERTER_CONTROL, 0);
         check("ctrl done", rd, 32'hc0c0 | (i << 3));
         apb(0, `OFS_FIRST_RESULT, 0);
         check("result", rd, {16'h0, 6'h20, i[2:0], 7'h35});
      end

      // Start by read; start bit is ignored meanwhile
      s0 = starts;
      apb(1, `OFS_CONVERTER_CONTROL, 32'h40d3);
      repeat (40) @(posedge pclk);
      check("start ignored", starts, s0);
      apb(0, `OFS_FIRST_RESULT, 0);
      apb(0, `OFS_CONVERTER_CONTROL, 0);
      check("read launch", rd[15], 1'b0);
      wait_for(irqs, irqs + 1);
      check("read start", starts, s0 + 1);
      apb(1, `OFS_CONVERTER_CONTROL, 32'h40d0);

      // Automatic X then Y
      apb(1, `OFS_TOUCH_PAD_CONTROL, 32'h05c);
      s0 = starts;
      i  = irqs;
      apb(1, `OFS_CONVERTER_CONTROL, 32'h40c1);
      wait_for(irqs, i + 1);
      check("auto starts", starts, s0 + 2);
      apb(0, `OFS_FIRST_RESULT, 0);
      check("x result", rd, {16'h0, 6'h30, 3'h5, 7'h35});
      apb(0, `OFS_SECOND_RESULT, 0);
      check("y result", rd, {16'h0, 6'h30, 3'h7, 7'h35});

      // Halt blocks conversion and keeps results
      apb(1, `OFS_TOUCH_PAD_CONTROL, 32'h058);
      s0 = starts;
      apb(1, `OFS_CONVERTER_CONTROL, 32'h40c5);
      repeat (60) @(posedge pclk);
      check("standby", adc_standby, 1'b1);
      check("halt starts", starts, s0);
      apb(0, `OFS_SECOND_RESULT, 0);
      check("held y", rd[9:0], {3'h7, 7'h35});
      apb(1, `OFS_CONVERTER_CONTROL, 32'h40c0);

      // Wait for touch, repeated at delay + 1
      apb(1, `OFS_CONVERSION_DELAY, 32'h4);
      apb(1, `OFS_TOUCH_PAD_CONTROL, 32'h0d3);
      settle();
      check("touch pads", {yminus_drive, yplus_drive_n, xminus_drive,
             xplus_drive_n, xplus_pullup_n}, 5'b11010);
      check("no touch", touches, 0);
      @(posedge pclk);
      pressed <= 1'b1;
      wait_for(touches, 3);
      check("touch gap", gap, 5);
      apb(0, `OFS_FIRST_RESULT, 0);
      check("stylus down", rd[15:12], 4'h3);
      pressed <= 1'b0;
      repeat (10) @(posedge pclk);
      apb(0, `OFS_FIRST_RESULT, 0);
      check("stylus up", rd[15:12], 4'hb);

      // Separate X measurement once the touch is seen
      apb(1, `OFS_TOUCH_PAD_CONTROL, 32'h069);
      settle();
      check("x pads", {yminus_drive, yplus_drive_n, xminus_drive,
             xplus_drive_n, xplus_pullup_n}, 5'b01101);
      i = irqs;
      apb(1, `OFS_CONVERTER_CONTROL, 32'h40e9);
      wait_for(irqs, i + 1);
      apb(0, `OFS_FIRST_RESULT, 0);
      check("x measure", rd, {16'h0, 6'h24, 3'h5, 7'h35});
      stop_test();
   end
endmodule : tb_touch_adc_control
